// file: src/tef_pkg.sv
package tef_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_MOD = 12'h004;
  localparam logic [11:0] OFF_CNT = 12'h008;
  localparam logic [11:0] OFF_FLAGS = 12'h00C;
  localparam logic [11:0] OFF_IRQEN = 12'h010;
  localparam logic [11:0] OFF_CH_BASE = 12'h020;
  localparam logic [11:0] CH_STRIDE = 12'h008;
  localparam logic [11:0] OFF_CH_CFG = 12'h000;
  localparam logic [11:0] OFF_CH_VAL = 12'h004;
  // ==========================================
  // field positions and values
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CAS_BIT = 1;
  localparam int FLAG_WRAP_BIT = 0;
  localparam int FLAG_CH_LSB = 1;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // ==========================================
  // channel modes
  typedef enum logic [1:0] {
    TEF_MODE_CAPTURE = 2'b00,
    TEF_MODE_COMPARE = 2'b01,
    TEF_MODE_EPWM = 2'b10
  } tef_mode_t;
  // edge select: {edge_level_select_hi, edge_level_select_lo}
  localparam logic [1:0] EDGE_OFF = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_FALL = 2'b10;
  localparam logic [1:0] EDGE_ANY = 2'b11;
  typedef struct packed {
    logic [1:0] mode;
    logic edge_level_select_hi;
    logic edge_level_select_lo;
  } tef_ch_cfg_t;
  localparam int CFG_W = 4;
  typedef struct packed {
    logic run;
    logic center_align_select;
  } tef_ctrl_t;
endpackage : tef_pkg

// file: src/tef_timer_flags.sv
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - a flag clears only after a read that sees it set and then a write of zero to it.
// - an event between that read and the zero write disarms the flag, the flag stays until read again.
// - plain up-counting with modulus zero runs 0000..FFFF and sets the wrap flag at wrap.
// - with a modulus set, the wrap flag sets when the count steps from modulus to zero.
// - up/down counting with a modulus set sets the wrap flag as the count turns down from the modulus.
// - capture channels set their flag on the rising, falling, either or no edge chosen; with center_align_select 1, on match instead.
// - compare channels set their flag each time the counter equals the match value.
// - edge pwm channels set their flag at the match that ends the active duty.
// - center pwm channels set their flag at both matches, up and down.
// - the irq output stays high while any flag is set with its enable set.
// - center_align_select 1 counts up to modulus then down to zero, 0 counts up only.
module tef_timer_flags #(
  parameter int NCH = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // channel pins and interrupt
  input wire logic [NCH-1:0] ch_in,
  output logic irq
);
  localparam int NF = NCH + 1;
  // ==========================================
  // state
  tef_pkg::tef_ctrl_t ctrl_reg, ctrl_next;
  logic [15:0] mod_reg, mod_next, cnt_reg, cnt_next;
  logic down_reg, down_next;
  logic [NF-1:0] flag_reg, flag_next, armed_reg, armed_next, ien_reg, ien_next;
  tef_pkg::tef_ch_cfg_t cfg_reg [NCH];
  tef_pkg::tef_ch_cfg_t cfg_next [NCH];
  logic [15:0] val_reg [NCH];
  logic [15:0] val_next [NCH];
  logic [NCH-1:0] pin_reg;
  logic [31:0] prdata_next;
  logic irq_next;
  logic pready_next;
  logic [NF-1:0] event_w;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // ==========================================
  // event detection
  logic wrap_ev;
  always_comb begin
    wrap_ev = 1'b0;
    if (ctrl_reg.run) begin
      if (ctrl_reg.center_align_select) begin
        wrap_ev = !down_reg && (cnt_reg == mod_reg) && (mod_reg != tef_pkg::CNT_ZERO);
      end else if (mod_reg == tef_pkg::CNT_ZERO) begin
        wrap_ev = (cnt_reg == tef_pkg::CNT_MAX);
      end else begin
        wrap_ev = (cnt_reg == mod_reg);
      end
    end
  end
  assign event_w[tef_pkg::FLAG_WRAP_BIT] = wrap_ev;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic rise, fall, match, ev;
      always_comb begin
        rise = ch_in[g] && !pin_reg[g];
        fall = !ch_in[g] && pin_reg[g];
        match = ctrl_reg.run && (cnt_reg == val_reg[g]);
        ev = 1'b0;
        if (ctrl_reg.center_align_select) begin
          ev = match;
        end else begin
          case (tef_pkg::tef_mode_t'(cfg_reg[g].mode))
            tef_pkg::TEF_MODE_CAPTURE: begin
              case ({cfg_reg[g].edge_level_select_hi, cfg_reg[g].edge_level_select_lo})
                tef_pkg::EDGE_RISE: ev = rise;
                tef_pkg::EDGE_FALL: ev = fall;
                tef_pkg::EDGE_ANY: ev = rise || fall;
                default: ev = 1'b0;
              endcase
            end
            tef_pkg::TEF_MODE_COMPARE: ev = match;
            tef_pkg::TEF_MODE_EPWM: ev = match;
            default: ev = 1'b0;
          endcase
        end
      end
      assign event_w[tef_pkg::FLAG_CH_LSB + g] = ev;
    end
  endgenerate

  // ==========================================
  // counter, registers, flags
  logic acc, wr, rd;
  logic [11:0] choff;
  always_comb begin
    acc = psel && penable;
    wr = acc && pwrite;
    rd = acc && !pwrite;
    ctrl_next = ctrl_reg;
    mod_next = mod_reg;
    cnt_next = cnt_reg;
    down_next = down_reg;
    ien_next = ien_reg;
    armed_next = armed_reg;
    flag_next = flag_reg;
    prdata_next = 32'h0000_0000;
    cfg_next = cfg_reg;
    val_next = val_reg;
    choff = 12'h000;
    // up/down reverses at modulus and at zero
    if (ctrl_reg.run) begin
      if (ctrl_reg.center_align_select) begin
        if (!down_reg && cnt_reg == mod_reg) begin
          down_next = 1'b1;
          cnt_next = cnt_reg - tef_pkg::CNT_ONE;
        end else if (down_reg && cnt_reg == tef_pkg::CNT_ZERO) begin
          down_next = 1'b0;
          cnt_next = cnt_reg + tef_pkg::CNT_ONE;
        end else begin
          cnt_next = down_reg ? cnt_reg - tef_pkg::CNT_ONE : cnt_reg + tef_pkg::CNT_ONE;
        end
      end else begin
        down_next = 1'b0;
        cnt_next = wrap_ev ? tef_pkg::CNT_ZERO : cnt_reg + tef_pkg::CNT_ONE;
      end
    end
    if (rd) begin
      if (hit(paddr, tef_pkg::OFF_CTRL)) begin
        prdata_next[tef_pkg::CTRL_RUN_BIT] = ctrl_reg.run;
        prdata_next[tef_pkg::CTRL_CAS_BIT] = ctrl_reg.center_align_select;
      end else if (hit(paddr, tef_pkg::OFF_MOD)) begin
        prdata_next = {16'h0000, mod_reg};
      end else if (hit(paddr, tef_pkg::OFF_CNT)) begin
        prdata_next = {16'h0000, cnt_reg};
      end else if (hit(paddr, tef_pkg::OFF_FLAGS)) begin
        prdata_next = 32'(flag_reg);
        armed_next = armed_reg | flag_reg;
      end else if (hit(paddr, tef_pkg::OFF_IRQEN)) begin
        prdata_next = 32'(ien_reg);
      end else begin
        for (int i = 0; i < NCH; i++) begin
          choff = tef_pkg::OFF_CH_BASE + 12'(i) * tef_pkg::CH_STRIDE;
          if (hit(paddr, choff + tef_pkg::OFF_CH_CFG)) begin
            prdata_next = 32'(cfg_reg[i]);
          end else if (hit(paddr, choff + tef_pkg::OFF_CH_VAL)) begin
            prdata_next = {16'h0000, val_reg[i]};
          end
        end
      end
    end
    if (wr) begin
      if (hit(paddr, tef_pkg::OFF_CTRL)) begin
        ctrl_next.run = pwdata[tef_pkg::CTRL_RUN_BIT];
        ctrl_next.center_align_select = pwdata[tef_pkg::CTRL_CAS_BIT];
        if (!pwdata[tef_pkg::CTRL_RUN_BIT]) begin
          cnt_next = tef_pkg::CNT_ZERO;
          down_next = 1'b0;
        end
      end else if (hit(paddr, tef_pkg::OFF_MOD)) begin
        mod_next = pwdata[15:0];
      end else if (hit(paddr, tef_pkg::OFF_CNT)) begin
        cnt_next = tef_pkg::CNT_ZERO;
        down_next = 1'b0;
      end else if (hit(paddr, tef_pkg::OFF_FLAGS)) begin
        // zero bits clear only where armed; one bits have no effect
        flag_next = flag_reg & ~(armed_reg & ~pwdata[NF-1:0]);
        armed_next = armed_reg & pwdata[NF-1:0];
      end else if (hit(paddr, tef_pkg::OFF_IRQEN)) begin
        ien_next = pwdata[NF-1:0];
      end else begin
        for (int i = 0; i < NCH; i++) begin
          choff = tef_pkg::OFF_CH_BASE + 12'(i) * tef_pkg::CH_STRIDE;
          if (hit(paddr, choff + tef_pkg::OFF_CH_CFG)) begin
            cfg_next[i] = pwdata[tef_pkg::CFG_W-1:0];
          end else if (hit(paddr, choff + tef_pkg::OFF_CH_VAL)) begin
            val_next[i] = pwdata[15:0];
          end
        end
      end
    end
    // events win: set flag and drop arming, so a later zero write cannot clear it
    flag_next = flag_next | event_w;
    armed_next = armed_next & ~event_w;
    irq_next = |(flag_next & ien_next);
    // one wait state: registered read data is ready by the edge pready is seen
    pready_next = psel && penable && !pready;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
      mod_reg <= tef_pkg::CNT_ZERO;
      cnt_reg <= tef_pkg::CNT_ZERO;
      down_reg <= 1'b0;
      ien_reg <= '0;
      armed_reg <= '0;
      flag_reg <= '0;
      pin_reg <= '0;
      prdata <= 32'h0000_0000;
      irq <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        cfg_reg[i] <= '0;
        val_reg[i] <= tef_pkg::CNT_ZERO;
      end
    end else begin
      ctrl_reg <= ctrl_next;
      mod_reg <= mod_next;
      cnt_reg <= cnt_next;
      down_reg <= down_next;
      ien_reg <= ien_next;
      armed_reg <= armed_next;
      flag_reg <= flag_next;
      pin_reg <= ch_in;
      prdata <= prdata_next;
      irq <= irq_next;
      cfg_reg <= cfg_next;
      val_reg <= val_next;
    end
  end

  // one-wait slave; unmapped reads return zero, no error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= pready_next;
      pslverr <= 1'b0;
    end
  end
endmodule : tef_timer_flags

// file: tb/tef_timer_flags_properties.sv
`timescale 1ns/1ps
// ==========
// port checks
module tef_timer_flags_properties #(
  parameter int NCH = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [NCH-1:0] ch_in,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_done = pready && !pwrite;
  slverr_zero_a: assert property (!pslverr) else $error("slave error seen");
  ready_phase_a: assert property (pready |-> psel && penable) else $error("stray ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  ready_time_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("ready late");
  // irq may only drop after a write clears a flag or an enable
  irq_fall_a: assert property ($fell(irq) |->
    $past(psel && pwrite) || $past(psel && pwrite, 2))
    else $error("irq fell alone");
  unmapped_zero_a: assert property (rd_done && paddr == 12'h100 |-> prdata == 32'h0)
    else $error("unmapped read nonzero");
  mod_width_a: assert property (rd_done && paddr == tef_pkg::OFF_MOD |-> prdata[31:16] == 16'h0)
    else $error("modulus upper bits");
  flag_width_a: assert property (rd_done && paddr == tef_pkg::OFF_FLAGS |->
    (prdata >> (NCH + 1)) == 32'h0)
    else $error("flag upper bits");
  cover property ($rose(irq));
  cover property (rd_done && paddr == tef_pkg::OFF_FLAGS && prdata[0]);
  cover property ($rose(ch_in[0]));
endmodule : tef_timer_flags_properties
bind tef_timer_flags tef_timer_flags_properties #(.NCH(NCH)) props_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_in(ch_in), .irq(irq));

// file: tb/tef_timer_flags_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tef_timer_flags_tb;
  localparam logic [11:0] CTL = tef_pkg::OFF_CTRL;
  localparam logic [11:0] FLG = tef_pkg::OFF_FLAGS;
  localparam logic [11:0] CH0 = tef_pkg::OFF_CH_BASE;
  localparam logic [11:0] CH1 = tef_pkg::OFF_CH_BASE + tef_pkg::CH_STRIDE;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr, exp_v;
  logic [1:0] ch_in;
  logic [31:0] expq[$];
  int failures = 0;
  int tests_run = 0;
  tef_timer_flags #(.NCH(2)) tef_timer_flags_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ch_in(ch_in), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  // ==========
  // apb master, one idle cycle after each transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      test_done();
    end
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  always @(posedge pclk) begin
    if (presetn && pready === 1'b1 && pwrite === 1'b0 && expq.size() > 0) begin
      exp_v = expq.pop_front();
      `CHK(prdata, exp_v)
    end
  end
  // ==========
  // main sequence
  initial begin
    lfsr = 32'h0001741A;
    {presetn, psel, penable, pwrite, paddr, pwdata, ch_in} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(FLG, 32'h0);
    wr(12'h100, 32'hFFFFFFFF);
    rd(12'h100, 32'h0);
    wr(tef_pkg::OFF_MOD, 32'h12340010);
    rd(tef_pkg::OFF_MOD, 32'h00000010);
    wr(tef_pkg::OFF_IRQEN, 32'h1);
    wr(CTL, 32'h1);
    repeat (40) begin
      @(posedge pclk);
      lfsr = lfsr_next(lfsr);
      ch_in <= lfsr[1:0]; // pin noise with capture off
    end
    @(posedge pclk);
    ch_in <= 2'b00;
    wr(CTL, 32'h0);
    `CHK(irq, 1'b1)
    wr(FLG, 32'h0);
    rd(FLG, 32'h1);
    wr(FLG, 32'h0);
    rd(FLG, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    for (int i = 0; i < 4; i++) begin
      wr(CH0, 32'(i));
      ch_in <= 2'b01;
      repeat (4) @(posedge pclk);
      rd(FLG, 32'(i[0]) << 1);
      wr(FLG, 32'h0);
      ch_in <= 2'b00;
      repeat (4) @(posedge pclk);
      rd(FLG, 32'(i[1]) << 1);
      wr(FLG, 32'h0);
    end
    ch_in <= 2'b01;
    repeat (4) @(posedge pclk);
    rd(FLG, 32'h2);
    ch_in <= 2'b00;
    repeat (4) @(posedge pclk);
    wr(FLG, 32'h0);
    rd(FLG, 32'h2);
    // pin edge lands on the edge that takes the zero write
    fork
      wr(FLG, 32'h0);
      begin
        @(posedge pclk);
        ch_in <= 2'b01;
      end
    join
    rd(FLG, 32'h2);
    ch_in <= 2'b00;
    repeat (2) @(posedge pclk);
    rd(FLG, 32'h2);
    wr(FLG, 32'h0);
    // match values first, so no stale match fires on the mode change
    wr(CH0 + 12'h4, 32'h5);
    wr(CH0, 32'h4);
    wr(CH1 + 12'h4, 32'hC);
    wr(CH1, 32'h8);
    wr(CTL, 32'h1);
    repeat (30) @(posedge pclk);
    wr(CTL, 32'h0);
    rd(FLG, 32'h7);
    wr(FLG, 32'h0);
    wr(tef_pkg::OFF_MOD, 32'h100);
    wr(CH0 + 12'h4, 32'h20);
    wr(CH1 + 12'h4, 32'h20);
    wr(CTL, 32'h3);
    repeat (60) @(posedge pclk);
    rd(FLG, 32'h6);
    wr(FLG, 32'h0);
    rd(FLG, 32'h0);
    repeat (220) @(posedge pclk);
    rd(FLG, 32'h1);
    wr(FLG, 32'h0);
    repeat (200) @(posedge pclk);
    rd(FLG, 32'h6);
    wr(CTL, 32'h0);
    wr(tef_pkg::OFF_MOD, 32'h0);
    wr(CTL, 32'h1);
    repeat (65400) @(posedge pclk);
    rd(FLG, 32'h6);
    repeat (200) @(posedge pclk);
    rd(FLG, 32'h7);
    test_done();
  end
endmodule : tef_timer_flags_tb
